// File: logic/mouse_rf_packet_framer.sv
// Packet framer for a wireless mouse: builds each packet and shifts it out on one serial line.
// Assumes software loads payload registers over APB and the transmitter samples txData.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps

module mouse_rf_packet_framer
    import mouse_rf_pkg::*;
#(
    parameter int PREAMBLE_LEN = PREAMBLE_BITS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // APB register bus.
    input mouse_rf_pkg::apb_req_t apbReq,
    output mouse_rf_pkg::apb_rsp_t apbRsp,
    // Transmitter side.
    output logic txData,
    output logic txEnable,
    output logic [2:0] channelCode
);
    import mouse_rf_pkg::*;

    localparam int FRAME_BITS = PREAMBLE_LEN + BODY_BITS;
    localparam int IDX_W = $clog2(FRAME_BITS + 1);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FRAME_BITS - 1);
    localparam logic [IDX_W-1:0] SYNC_FIRST = IDX_W'(PREAMBLE_LEN);
    localparam logic [IDX_W-1:0] SYNC_END = IDX_W'(PREAMBLE_LEN + SYNC_BITS);

    // CRC-8 over the four payload bytes, most significant bit first.
    function automatic logic [7:0] crc8(input logic [31:0] data);
        logic [7:0] crc;
        logic fb;
        crc = CRC_SEED;
        for (int i = 31; i >= 0; i--) begin
            fb = crc[7] ^ data[i];
            crc = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return crc;
    endfunction

    // Software-visible state, plus the identifier generator.
    logic [1:0] typeQ;
    logic classQ;
    logic [7:0] motionXQ;
    logic [7:0] motionYQ;
    logic [4:0] buttonsQ;
    logic [7:0] wheelQ;
    logic [2:0] newChanQ;
    logic [2:0] chanQ;
    logic [15:0] testQ;
    logic [15:0] halfDivQ;
    logic [7:0] linkIdQ;
    logic [7:0] pendingIdQ;
    logic [7:0] lfsrQ;

    // Framer state.
    framer_state_t stateQ;
    logic [FRAME_BITS-1:0] frameQ;
    logic [IDX_W-1:0] bitIdxQ;
    logic phaseQ;
    logic [15:0] divCntQ;
    logic lineQ;
    logic bindingQ;

    // APB answer registers.
    logic preadyQ;
    logic pslverrQ;
    logic [31:0] prdataQ;

    // APB decode: the access phase is two cycles, data and errors are latched.
    wire accessPhase = apbReq.psel & apbReq.penable;
    wire takeAccess = accessPhase & ~preadyQ;
    wire doWrite = accessPhase & preadyQ & apbReq.pwrite & ~pslverrQ;
    wire selCtrl = apbReq.paddr == CTRL_OFS;
    wire selStatus = apbReq.paddr == STATUS_OFS;
    wire selMotion = apbReq.paddr == MOTION_OFS;
    wire selButton = apbReq.paddr == BUTTON_OFS;
    wire selChannel = apbReq.paddr == CHANNEL_OFS;
    wire selTest = apbReq.paddr == TEST_OFS;
    wire selDivider = apbReq.paddr == DIVIDER_OFS;
    wire mapped = selCtrl | selStatus | selMotion | selButton | selChannel | selTest | selDivider;
    wire busy = stateQ == SEND;
    wire [31:0] wdata = apbReq.pwdata;
    wire startReq = doWrite & selCtrl & wdata[CTRL_START_BIT] & ~busy;
    wire newIdReq = doWrite & selCtrl & wdata[CTRL_NEWID_BIT];

    // Read multiplexer; reserved bits read as zero.
    // Status packs busy, the pending and link identifiers and the channel in use.
    wire [31:0] readMux =
        selCtrl ? {23'h0, classQ, 2'h0, typeQ, 4'h0} :
        selStatus ? {5'h0, chanQ, linkIdQ, pendingIdQ, 7'h0, busy} :
        selMotion ? {16'h0, motionXQ, motionYQ} :
        selButton ? {16'h0, 3'h0, buttonsQ, wheelQ} :
        selChannel ? {29'h0, newChanQ} :
        selTest ? {16'h0, testQ} :
        selDivider ? {16'h0, halfDivQ} : 32'h0;

    // Identifier candidate from the generator, steered away from all ones.
    wire [7:0] lfsrNext = {lfsrQ[6:0], lfsrQ[7] ^ lfsrQ[5] ^ lfsrQ[4] ^ lfsrQ[3]};
    wire [7:0] idCandidate = (lfsrQ == ID_RESET) ? (lfsrQ ^ 8'h01) : lfsrQ;

    // Payload assembly by type.
    // The write that starts a packet may also set its type and class, so the frame takes them at once.
    wire ctrlWrite = doWrite & selCtrl;
    wire [1:0] typeNow = ctrlWrite ? wdata[CTRL_TYPE_LSB +: 2] : typeQ;
    wire classNow = ctrlWrite ? wdata[CTRL_CLASS_BIT] : classQ;
    wire [7:0] wheelLimited = (wheelQ == 8'h80) ? WHEEL_MIN : wheelQ;
    wire [7:0] chanByte = {1'b0, chanQ, 1'b0, newChanQ};
    wire [7:0] buttonByte = {3'h0, buttonsQ};
    wire [7:0] headerByte = {classNow, 5'h0, typeNow};
    logic [7:0] upperByte;
    logic [7:0] lowerByte;

    // Data byte selection per payload type.
    always_comb begin
        case (typeNow)
            TYPE_ID_CHANGE: begin
                upperByte = chanByte;
                lowerByte = pendingIdQ;
            end
            TYPE_MOTION: begin
                upperByte = motionXQ;
                lowerByte = motionYQ;
            end
            TYPE_BUTTONS: begin
                upperByte = buttonByte;
                lowerByte = wheelLimited;
            end
            default: begin
                upperByte = testQ[15:8];
                lowerByte = testQ[7:0];
            end
        endcase
    end

    // The checksum is worked out from the live payload and frozen with the rest of the frame.
    payload_t payload;
    assign payload = '{linkId: linkIdQ, header: headerByte, upper: upperByte, lower: lowerByte};
    wire [7:0] checksum = crc8(payload);
    wire [FRAME_BITS-1:0] frameNext = {{PREAMBLE_LEN{1'b1}}, SYNC_PATTERN, payload, checksum, STOP_PATTERN};

    // Bit timing and coding decisions for the current bit.
    wire tick = busy & (divCntQ == 16'h0);
    wire curBit = frameQ[FRAME_BITS-1];
    wire nextBit = frameQ[FRAME_BITS-2];
    wire [IDX_W-1:0] nextIdx = bitIdxQ + IDX_W'(1);
    wire inSync = (bitIdxQ >= SYNC_FIRST) & (bitIdxQ < SYNC_END);
    wire nextInSync = (nextIdx >= SYNC_FIRST) & (nextIdx < SYNC_END);
    wire lastBit = bitIdxQ == LAST_IDX;
    wire midTick = tick & ~phaseQ;
    wire edgeTick = tick & phaseQ;
    wire frameEnd = edgeTick & lastBit;
    logic lineD;

    // Miller coding: a one toggles mid-bit, a zero after a zero toggles at the bit edge.
    // The first tick of a bit is its middle, the second its end and the start of the next bit.
    // So every bit owns two whole half-bits on the line, and the last one is not cut short.
    // Sync bits are raw levels held for the whole bit; coding resumes from that level.
    always_comb begin
        lineD = lineQ;
        if (midTick) begin
            if (!inSync) begin
                lineD = curBit ? ~lineQ : lineQ;
            end
        end else if (edgeTick) begin
            if (nextInSync) begin
                lineD = nextBit;
            end else begin
                lineD = (!curBit && !nextBit) ? ~lineQ : lineQ;
            end
        end
    end

    // APB answer: pready one cycle into the access phase, unmapped addresses flag an error.
    // The answer is registered, so every transfer takes exactly two access cycles.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preadyQ <= 1'b0;
            pslverrQ <= 1'b0;
            prdataQ <= 32'h0;
        end else begin
            preadyQ <= takeAccess;
            pslverrQ <= takeAccess & ~mapped;
            prdataQ <= (takeAccess & ~apbReq.pwrite) ? readMux : 32'h0;
        end
    end

    // Payload and configuration registers written by software.
    // Writes that end with a slave error change nothing.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            typeQ <= TYPE_ID_CHANGE;
            classQ <= CLASS_RESET;
            motionXQ <= 8'h0;
            motionYQ <= 8'h0;
            buttonsQ <= 5'h0;
            wheelQ <= 8'h0;
            newChanQ <= CHANNEL_RESET;
            testQ <= 16'h0;
            halfDivQ <= HALF_BIT_RESET;
        end else if (doWrite) begin
            if (selCtrl) begin
                typeQ <= wdata[CTRL_TYPE_LSB +: 2];
                classQ <= wdata[CTRL_CLASS_BIT];
            end
            if (selMotion) begin
                motionXQ <= wdata[15:8];
                motionYQ <= wdata[7:0];
            end
            if (selButton) begin
                buttonsQ <= wdata[12:8];
                wheelQ <= wdata[7:0];
            end
            if (selChannel) begin
                newChanQ <= wdata[2:0];
            end
            if (selTest) begin
                testQ <= wdata[15:0];
            end
            if (selDivider) begin
                halfDivQ <= (wdata[15:0] == 16'h0) ? 16'h1 : wdata[15:0];
            end
        end
    end

    // Identifier generator and the identifier currently on the air.
    // A draw is refused while a packet is on the air; one in the write that starts a packet is taken after that frame has latched the old value.
    // A new identifier goes on the air when a binding packet ends, unannounced if it was drawn in that packet's start write.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsrQ <= LFSR_RESET;
            linkIdQ <= ID_RESET;
            pendingIdQ <= ID_RESET;
        end else begin
            lfsrQ <= lfsrNext;
            if (newIdReq && !busy) begin
                pendingIdQ <= idCandidate;
            end
            if (tick && phaseQ && lastBit && bindingQ) begin
                linkIdQ <= pendingIdQ;
            end
        end
    end

    // Channel in use; a binding packet moves it to the new code once sent.
    // Until then the old code stays on the pins, so the carrier never moves mid-packet.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chanQ <= CHANNEL_RESET;
        end else if (tick && phaseQ && lastBit && bindingQ) begin
            chanQ <= newChanQ;
        end
    end

    // Half-bit divider; it restarts with each packet one cycle longer, behind the registered enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCntQ <= 16'h0;
        end else if (startReq) begin
            divCntQ <= halfDivQ; // The first half-bit then lasts a full half-bit on the line.
        end else if (divCntQ == 16'h0) begin
            divCntQ <= halfDivQ - 16'h1;
        end else begin
            divCntQ <= divCntQ - 16'h1;
        end
    end

    // Frame sequencer: one shift per bit, two half-bit phases each.
    // The frame is latched whole at the start, so later writes only shape the next packet.
    // A start while a packet is on the air is dropped without any flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= IDLE;
            frameQ <= '0;
            bitIdxQ <= '0;
            phaseQ <= 1'b0;
            bindingQ <= 1'b0;
        end else begin
            case (stateQ)
                IDLE: begin
                    if (startReq) begin
                        stateQ <= SEND;
                        frameQ <= frameNext;
                        bitIdxQ <= '0;
                        phaseQ <= 1'b0;
                        bindingQ <= typeNow == TYPE_ID_CHANGE;
                    end
                end
                SEND: begin
                    if (tick) begin
                        phaseQ <= ~phaseQ;
                        if (phaseQ) begin
                            frameQ <= {frameQ[FRAME_BITS-2:0], 1'b1};
                            bitIdxQ <= bitIdxQ + IDX_W'(1);
                            if (lastBit) begin
                                stateQ <= IDLE;
                            end
                        end
                    end
                end
                default: begin
                    stateQ <= IDLE;
                end
            endcase
        end
    end

    // Line level and transmitter enable.
    // The line returns low together with the enable, so no stray level follows a packet.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineQ <= 1'b0;
            txEnable <= 1'b0;
        end else begin
            lineQ <= (busy & ~frameEnd) ? lineD : 1'b0;
            txEnable <= busy & ~frameEnd;
        end
    end

    assign txData = lineQ;
    assign channelCode = chanQ;
    assign apbRsp = '{pready: preadyQ, pslverr: pslverrQ, prdata: prdataQ};

endmodule

// File: logic/mouse_rf_pkg.sv
// Package for the mouse RF packet framer: register map, reset values, frame layout and types.
// Assumes a 32-bit APB register bus and a single 25 MHz clock.
package mouse_rf_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MOTION_OFS = 8'h08;
    localparam logic [7:0] BUTTON_OFS = 8'h0c;
    localparam logic [7:0] CHANNEL_OFS = 8'h10;
    localparam logic [7:0] TEST_OFS = 8'h14;
    localparam logic [7:0] DIVIDER_OFS = 8'h18;

    // Control register field positions.
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_NEWID_BIT = 1;
    localparam int CTRL_TYPE_LSB = 4;
    localparam int CTRL_CLASS_BIT = 8;

    // Values after reset.
    localparam logic [7:0] ID_RESET = 8'hff;
    localparam logic [7:0] LFSR_RESET = 8'h01;
    localparam logic [15:0] HALF_BIT_RESET = 16'h0032;
    localparam logic CLASS_RESET = 1'b1;
    localparam logic [2:0] CHANNEL_RESET = 3'h0;

    // Frame layout constants.
    localparam int PREAMBLE_BITS = 10;
    localparam int BODY_BITS = 48;
    localparam int SYNC_BITS = 6;
    localparam logic [5:0] SYNC_PATTERN = 6'h27;
    localparam logic [1:0] STOP_PATTERN = 2'h3;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'h00;
    localparam logic [7:0] WHEEL_MIN = 8'h81;

    // Payload type codes carried in the header's two low bits.
    localparam logic [1:0] TYPE_ID_CHANGE = 2'h0;
    localparam logic [1:0] TYPE_MOTION = 2'h1;
    localparam logic [1:0] TYPE_BUTTONS = 2'h2;
    localparam logic [1:0] TYPE_TEST = 2'h3;

    // One APB request from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // One APB answer from the slave.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // Four bytes covered by the checksum.
    typedef struct packed {
        logic [7:0] linkId;
        logic [7:0] header;
        logic [7:0] upper;
        logic [7:0] lower;
    } payload_t;

    typedef enum logic {IDLE, SEND} framer_state_t;

endpackage

// File: tb/mouse_rf_framer_sva.sv
// Concurrent checks on the framer's ports.
// Bound into every framer instance; follows the half-bit divider from APB writes.
`timescale 1ns/1ps
module mouse_rf_framer_sva
    import mouse_rf_pkg::*;
#(
    parameter int PREAMBLE_LEN = PREAMBLE_BITS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register bus.
    input mouse_rf_pkg::apb_req_t apbReq,
    input mouse_rf_pkg::apb_rsp_t apbRsp,
    // Transmitter side.
    input wire logic txData,
    input wire logic txEnable,
    input wire logic [2:0] channelCode
);
    logic [15:0] half_q;
    int len_q;
    // Decoded bus events.
    wire wrDone = apbRsp.pready && apbReq.pwrite;
    wire divWr = wrDone && apbReq.paddr == DIVIDER_OFS;
    wire ctrlStart = wrDone && apbReq.paddr == CTRL_OFS && apbReq.pwdata[0];

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Tracks the divider and how many cycles the current transmission has lasted.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= HALF_BIT_RESET;
            len_q <= 0;
        end else begin
            if (divWr) begin
                half_q <= (apbReq.pwdata[15:0] == 16'h0000) ? 16'h0001 : apbReq.pwdata[15:0];
            end
            len_q <= txEnable ? len_q + 1 : 0;
        end
    end

    sequence accessWait;
        apbReq.psel && apbReq.penable && !apbRsp.pready;
    endsequence

    ready_after_access_a: assert property (accessWait |=> apbRsp.pready)
        else $error("No ready after the first access cycle.");
    ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("Ready held for more than one cycle.");
    err_only_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("Error flag without ready.");
    err_unmapped_a: assert property (apbRsp.pready && apbReq.paddr > DIVIDER_OFS |-> apbRsp.pslverr)
        else $error("Unmapped address answered without error.");
    rdata_quiet_a: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0000_0000)
        else $error("Read data not zero outside an answer.");
    start_launch_a: assert property (ctrlStart && !txEnable |-> ##2 txEnable)
        else $error("Start write did not raise the enable.");
    frame_len_a: assert property ($fell(txEnable) |-> len_q >= 2 * (PREAMBLE_LEN + BODY_BITS) * half_q
        && len_q <= (2 * (PREAMBLE_LEN + BODY_BITS) + 1) * half_q + 1)
        else $error("Transmission length is not the packet length.");
    enable_hold_a: assert property ($rose(txEnable) |-> txEnable [*8])
        else $error("Enable dropped right after it rose.");
    idle_low_a: assert property (!txEnable && !$past(txEnable) |-> !txData)
        else $error("Line not low while idle.");
    chan_steady_a: assert property ($changed(channelCode) |-> !txEnable)
        else $error("Channel changed during a packet.");
endmodule

bind mouse_rf_packet_framer mouse_rf_framer_sva #(.PREAMBLE_LEN(PREAMBLE_LEN)) u_mouse_rf_framer_sva (
    .clk(clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .txData(txData), .txEnable(txEnable), .channelCode(channelCode));

// File: tb/rf_receiver_model.sv
// Receiver model: records the serial line during each packet and decodes it.
// Assumes HALF clocks per half bit and that a packet ends on its last half-bit.
`timescale 1ns/1ps
module rf_receiver_model
    import mouse_rf_pkg::*;
#(
    parameter int HALF = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Serial line.
    input wire logic txData,
    input wire logic txEnable,
    // Decoded packet.
    output logic [57:0] rxFrame,
    output int rxCount
);
    localparam int NBITS = PREAMBLE_BITS + BODY_BITS;
    logic trace[$];

    // Decodes from the end backwards, since the start offset may vary by a half bit.
    always @(posedge clk or negedge rst_n) begin : decode
        logic [NBITS-1:0] f;
        int e;
        if (!rst_n) begin
            trace.delete();
            rxCount <= 0;
            rxFrame <= '0;
        end else if (txEnable) begin
            trace.push_back(txData);
        end else if (trace.size() > 0) begin
            for (int b = 0; b < NBITS; b++) begin
                e = trace.size() - 1 - (2 * (NBITS - b) - 1) * HALF - HALF / 2;
                if (e < 0) begin
                    f[NBITS-1-b] = 1'b0;
                end else if (b >= PREAMBLE_BITS && b < PREAMBLE_BITS + SYNC_BITS) begin
                    f[NBITS-1-b] = trace[e];
                end else begin
                    f[NBITS-1-b] = trace[e] ^ trace[e+HALF];
                end
            end
            rxFrame <= f;
            rxCount <= rxCount + 1;
            trace.delete();
        end
    end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the mouse packet framer.
// Drives APB as master and judges the line through the receiver model.
`timescale 1ns/1ps
module testbench;
    import mouse_rf_pkg::*;
    localparam int HALF = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_t apbReq = '0;
    apb_rsp_t apbRsp;
    logic txData;
    logic txEnable;
    logic [2:0] channelCode;
    logic [57:0] rxFrame;
    int rxCount;
    int fails = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] linkId = 8'hff;
    logic [2:0] oldChan = 3'h0;

    // Clock at 25 MHz.
    always #20 clk = ~clk;

    mouse_rf_packet_framer u_mouse_rf_packet_framer (.clk(clk), .rst_n(rst_n), .apbReq(apbReq),
        .apbRsp(apbRsp), .txData(txData), .txEnable(txEnable), .channelCode(channelCode));
    rf_receiver_model #(.HALF(HALF)) u_rf_receiver_model (.clk(clk), .rst_n(rst_n), .txData(txData),
        .txEnable(txEnable), .rxFrame(rxFrame), .rxCount(rxCount));

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; holds the request until ready is seen.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n = 0;
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
        if (n >= 20) check(1'b0, 1'b1, "bus answer");
    endtask

    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] c = 8'h00;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // Starts a packet, optionally retries while busy, and compares the decoded frame.
    task automatic send(input logic [1:0] kind, input logic cls, input logic [7:0] up, input logic [7:0] lo,
        input logic busyTry);
        logic [31:0] body;
        int c0;
        int n = 0;
        body = {linkId, cls, 5'b00000, kind, up, lo};
        c0 = rxCount;
        apb(1'b1, CTRL_OFS, {23'h0, cls, 2'b00, kind, 4'h1});
        if (busyTry) begin
            apb(1'b1, CTRL_OFS, 32'h0000_0011);
            apb(1'b0, STATUS_OFS, 32'h0);
            check(rd[0], 1'b1, "busy flag");
        end
        while (rxCount == c0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (8 * HALF) @(posedge clk);
        check({txEnable, 32'(rxCount)}, c0 + 1, "one packet, then idle");
        check(rxFrame, {{PREAMBLE_BITS{1'b1}}, 6'b100111, body, crc8(body), 2'b11}, "frame");
    endtask

    task automatic test_reset;
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd[26:16], 11'h0ff, "reset id and channel");
        check(channelCode, 3'h0, "reset channel pin");
        apb(1'b0, 8'h1c, 32'h0);
        check({err, rd}, 33'h1_0000_0000, "unmapped read");
        $display("test_reset done");
    endtask

    task automatic test_payloads;
        apb(1'b1, DIVIDER_OFS, 32'(HALF));
        apb(1'b1, MOTION_OFS, 32'h0000_857f);
        send(2'b01, 1'b1, 8'h85, 8'h7f, 1'b1);
        apb(1'b1, BUTTON_OFS, 32'h0000_1580);
        send(2'b10, 1'b0, 8'h15, 8'h81, 1'b0);
        apb(1'b1, TEST_OFS, 32'h0000_a55a);
        send(2'b11, 1'b1, 8'ha5, 8'h5a, 1'b0);
        $display("test_payloads done");
    endtask

    task automatic test_bind;
        logic [7:0] pid;
        logic [2:0] code;
        for (int i = 0; i < 2; i++) begin
            code = (i == 0) ? 3'h5 : 3'h2;
            apb(1'b1, CTRL_OFS, 32'h0000_0002);
            apb(1'b0, STATUS_OFS, 32'h0);
            pid = rd[15:8];
            check(pid == 8'hff, 1'b0, "drawn id");
            apb(1'b1, CHANNEL_OFS, {29'h0, code});
            send(2'b00, 1'b1, {1'b0, oldChan, 1'b0, code}, pid, 1'b0);
            linkId = pid;
            oldChan = code;
            apb(1'b0, STATUS_OFS, 32'h0);
            check(rd[26:16], {code, pid}, "link after binding");
            check(channelCode, code, "channel pin");
        end
        $display("test_bind done");
    endtask

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_payloads();
        test_bind();
        give_verdict();
    end

    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule
